// ### rtl/fwph_pkg.sv
/*
 * Shared constants for the flash write-protect and serial-pause block:
 * status word layout, command codes, erase sizes and operation kinds.
 * Assumes a byte-wide serial command stream, most significant bit first.
 */
package fwph_pkg;
    // Array address width, 8 MB of byte addresses
    localparam int ADDR_W = 23;
    // Status word width and bit positions
    localparam int SR_W = 16;
    localparam int SB_BUSY = 0;
    localparam int SB_WEL = 1;
    localparam int SB_GUARD_LO = 2;
    localparam int SB_GUARD_HI = 6;
    localparam int SB_LOCK_LO = 7;
    localparam int SB_LOCK_HI = 8;
    localparam int SB_QUAD = 9;
    localparam int SB_SEC_A = 10;
    localparam int SB_SEC_B = 11;
    localparam int SB_SCHEME = 12;
    localparam int SB_PAUSE_SEL = 13;
    localparam int SB_INVERT = 14;
    // Power-up value of the stored status bits
    localparam logic [15:0] SR_RESET = 16'h0000;
    // Bits that a status write may change; busy, latch, bit 15 are fixed
    localparam logic [15:0] SR_WMASK = 16'h7ffc;
    // Guard and lock bits frozen while the guard pin is low
    localparam logic [15:0] SR_HW_MASK = 16'h01fc;
    // One-time lock bits: once set they stay set
    localparam logic [15:0] SR_OTP_MASK = 16'h0c00;
    // Lock selector codes
    localparam logic [1:0] LOCK_PIN = 2'h1;
    // Command codes
    localparam logic [7:0] CMD_ARM = 8'h06;
    localparam logic [7:0] CMD_DISARM = 8'h04;
    localparam logic [7:0] CMD_RD_LO = 8'h05;
    localparam logic [7:0] CMD_RD_HI = 8'h35;
    localparam logic [7:0] CMD_SR_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE = 8'h02;
    localparam logic [7:0] CMD_SECTOR = 8'h20;
    localparam logic [7:0] CMD_BLK32 = 8'h52;
    localparam logic [7:0] CMD_BLK64 = 8'hd8;
    localparam logic [7:0] CMD_CHIP_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_B = 8'hc7;
    localparam logic [7:0] CMD_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WAKE = 8'hab;
    // Log2 of the erased or programmed span
    localparam logic [4:0] LOG_PAGE = 5'h08;
    localparam logic [4:0] LOG_SECTOR = 5'h0c;
    localparam logic [4:0] LOG_BLK32 = 5'h0f;
    localparam logic [4:0] LOG_BLK64 = 5'h10;
    // Region decode: log2 of smallest fraction and smallest top block
    localparam logic [4:0] LOG_FRAC_BASE = 5'h11;
    localparam logic [4:0] LOG_BLOCK_BASE = 5'h0c;
    localparam logic [2:0] BLOCK_STEP_MAX = 3'h3;
    // Command byte counts
    localparam logic [2:0] NB_ADDR = 3'h4;
    localparam logic [2:0] NB_SR_LO = 3'h2;
    localparam logic [2:0] NB_SR_FULL = 3'h3;
    // Internal operation kinds
    typedef enum logic [2:0] {
        OPK_NONE,
        OPK_SRW,
        OPK_PAGE,
        OPK_SECTOR,
        OPK_BLOCK,
        OPK_CHIP
    } fwph_op_t;
endpackage

// ### rtl/fwph_region.sv
/*
 * Protected-region decode for one byte address.
 * Assumes guard code and invert bit come straight from the status word.
 */
`timescale 1ns/10ps
module fwph_region
    import fwph_pkg::*;
(
    input wire logic [4:0] guard_i,
    input wire logic invert_i,
    input wire logic [ADDR_W-1:0] addr_i,
    output logic prot_o
);
    // Mask of address bits above a power-of-two span
    function automatic logic [ADDR_W-1:0] hi_mask(input logic [4:0] lg);
        hi_mask = ~((ADDR_W'(1) << lg) - ADDR_W'(1));
    endfunction

    // Region decode, then optional complement
    always_comb begin
        logic [2:0] step;
        logic [4:0] lg;
        logic [ADDR_W-1:0] m;
        logic base;
        step = guard_i[2:0] - 3'h1;
        lg = LOG_FRAC_BASE;
        m = '0;
        base = 1'b0;
        if (guard_i[2:0] == 3'h0) begin
            base = 1'b0; // Nothing guarded [RULE12]
        end else if (guard_i[2:0] == 3'h7) begin
            base = 1'b1; // Whole array guarded [RULE12]
        end else begin
            // Small blocks stop growing at the largest step [RULE12]
            if (guard_i[4]) begin
                if (step > BLOCK_STEP_MAX) begin
                    step = BLOCK_STEP_MAX;
                end
                lg = LOG_BLOCK_BASE + {2'h0, step};
            end else begin
                lg = LOG_FRAC_BASE + {2'h0, step};
            end
            m = hi_mask(lg);
            // Bit 3 picks the bottom end over the top [RULE12]
            if (guard_i[3]) begin
                base = ((addr_i & m) == '0);
            end else begin
                base = ((addr_i & m) == m);
            end
        end
        prot_o = base ^ invert_i; // Complement option [RULE13]
    end
endmodule

// ### rtl/fwph_sync.sv
/*
 * Two-stage level synchroniser of parameter width.
 * Assumes each bit is a level that is stable for several destination clocks.
 */
`timescale 1ns/10ps
module fwph_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage, read only by the second
    logic [W-1:0] meta_reg;
    // Second stage, safe to use
    logic [W-1:0] safe_reg;

    // Plain two-flop chain
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            safe_reg <= '0;
        end else begin
            meta_reg <= d_i;
            safe_reg <= meta_reg;
        end
    end

    assign q_o = safe_reg;
endmodule

// ### rtl/fwph_top.sv
/*
 * Write protection and serial pause logic of a serial NOR flash.
 * The serial side runs on the host's serial clock; status, latch, region
 * checks and the busy timer run on CLOCK_I. Assumes the host keeps the
 * serial clock still while chip select is high.
 */
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Pause never stops a running internal operation
// [RULE2] Pause starts at low clock, select low
// [RULE3] Pause ends at low clock after release
// [RULE4] Paused clock edges shift and latch nothing
// [RULE5] Select high during pause resets serial logic
// [RULE6] Host raises pause pin before next select
// [RULE7] Arm command sets latch flag, bit one
// [RULE8] Disarm and writes clear the latch flag
// [RULE9] Guarded region readable but never modified
// [RULE10] Guard pin low freezes guard, lock bits
// [RULE11] Deep sleep ignores all but wake
// [RULE12] Guard code selects fraction or small block
// [RULE13] Invert bit complements the guarded region
// [RULE14] Sixteen-bit status word field layout
// [RULE15] Busy flag reads one during operations
// [RULE16] Clear latch rejects every write command
// [RULE17] Lock code one with pin low locks
// [RULE18] Chip erase only with empty guarded region
// [RULE19] Paused output floats, shift position kept
module fwph_top
    import fwph_pkg::*;
#(
    parameter int CNT_W = 24,
    parameter int unsigned SRW_CYC = 2000,
    parameter int unsigned PAGE_CYC = 4000,
    parameter int unsigned SECTOR_CYC = 8000,
    parameter int unsigned BLOCK_CYC = 16000,
    parameter int unsigned CHIP_CYC = 32000
) (
    input wire logic CLOCK_I,
    input wire logic ARST_N_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    output logic SO_O,
    output logic SO_OE_O,
    output logic [15:0] STATUS_O,
    output logic OP_START_O,
    output logic [2:0] OP_KIND_O,
    output logic [ADDR_W-1:0] OP_ADDR_O,
    output logic PAUSED_O
);
    // Counter must hold the chip erase count, taken as the longest operation
    if (CNT_W < 2 || CNT_W > 32 || CHIP_CYC >= (64'd1 << CNT_W) ||
        SRW_CYC == 0 || PAGE_CYC == 0 || SECTOR_CYC == 0 ||
        BLOCK_CYC == 0 || CHIP_CYC == 0) begin : bad_cfg
        $error("fwph_top: operation counts do not fit the counter");
    end

    // Serial-side state cleared by select high
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] in_sh;
        logic [7:0] opcode;
        logic [7:0] tx_byte;
        logic reading;
    } fwph_lctl_t;
    // Serial-side frame record, kept after select rises
    typedef struct packed {
        logic tog;
        logic [7:0] op;
        logic [23:0] addr;
        logic [2:0] nbytes;
        logic aligned;
    } fwph_lrec_t;
    // Core-side state
    typedef struct packed {
        logic hold_act;
        logic cs_prev;
        logic seen_tog;
        logic [15:0] sr;
        logic write_latch_flag;
        logic busy;
        logic [CNT_W-1:0] cnt;
        fwph_op_t op;
        logic dpd;
        logic [15:0] sr_pend;
        logic op_start;
        logic [ADDR_W-1:0] op_addr;
    } fwph_core_t;

    fwph_lctl_t lc_reg, lc_next;
    fwph_lrec_t lr_reg, lr_next;
    fwph_core_t c_reg, c_next;
    logic link_rst_n; // Serial reset, select high or power reset
    logic so_reg; // Output bit, changes on falling clock
    logic so_oe_reg; // Output drive, changes on falling clock
    logic [16:0] stat_l; // Status and sleep flag on serial clock
    logic [4:0] core_s; // Synchronised pins and frame toggle
    logic cs_n_s, hold_n_s, sclk_s, wp_n_s, tog_s;
    logic [15:0] status_word;
    logic prot_s, prot_e; // Guard hits at span start and end
    logic [ADDR_W-1:0] span_mask, start_a, end_a;
    logic exec, sr_locked, chip_ok;
    logic [15:0] sr_new;

    // Serial logic restarts whenever select is high [RULE5]
    assign link_rst_n = ARST_N_I & ~CS_N_I;

    // Status crosses to the serial clock bit by bit; only the timer's end (busy,
    // latch, written status bits) moves it mid-frame, the rest change with select high
    fwph_sync #(.W(17)) u_stat_sync (
        .clk_i(SCLK_I),
        .rst_n_i(ARST_N_I),
        .d_i({c_reg.dpd, status_word}),
        .q_o(stat_l)
    );

    // Serial shift-in, byte capture and read data select
    always_comb begin
        logic [7:0] bv;
        logic [7:0] opv;
        lc_next = lc_reg;
        lr_next = lr_reg;
        bv = {lc_reg.in_sh[6:0], SI_I};
        opv = (lc_reg.byte_cnt == 3'h0) ? bv : lc_reg.opcode;
        // Paused edges change nothing [RULE4]
        if (HOLD_N_I) begin
            lc_next.in_sh = bv;
            lc_next.bit_cnt = lc_reg.bit_cnt + 3'h1;
            // First edge of a frame opens a new record
            if (lc_reg.bit_cnt == 3'h0 && lc_reg.byte_cnt == 3'h0) begin
                lr_next.tog = ~lr_reg.tog;
                lr_next.nbytes = 3'h0;
            end
            lr_next.aligned = (lc_reg.bit_cnt == 3'h7);
            if (lc_reg.bit_cnt == 3'h7) begin
                // Byte count saturates, later bytes are payload
                if (lc_reg.byte_cnt != 3'h7) begin
                    lc_next.byte_cnt = lc_reg.byte_cnt + 3'h1;
                end
                lr_next.nbytes = lc_next.byte_cnt;
                case (lc_reg.byte_cnt)
                    3'h0: begin
                        lc_next.opcode = bv;
                        lr_next.op = bv;
                    end
                    3'h1: lr_next.addr[23:16] = bv;
                    3'h2: lr_next.addr[15:8] = bv;
                    3'h3: lr_next.addr[7:0] = bv;
                    default: lr_next.addr = lr_reg.addr;
                endcase
                // Status reads repeat the same byte; sleep mutes them
                lc_next.tx_byte = (opv == CMD_RD_HI) ? stat_l[15:8]
                                                     : stat_l[7:0];
                lc_next.reading = ~stat_l[16] &
                    (opv == CMD_RD_LO || opv == CMD_RD_HI);
            end
        end
    end

    // Counters and shifter; select high clears them
    always_ff @(posedge SCLK_I or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lc_reg <= '0;
        end else begin
            lc_reg <= lc_next;
        end
    end

    // Frame record survives select high for the core to read
    always_ff @(posedge SCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lr_reg <= '0;
        end else begin
            lr_reg <= lr_next;
        end
    end

    // Data out on the falling edge, frozen while paused [RULE19]
    always_ff @(negedge SCLK_I or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else if (HOLD_N_I) begin
            so_reg <= lc_reg.tx_byte[~lc_reg.bit_cnt];
            so_oe_reg <= lc_reg.reading;
        end
    end

    // Output floats during a pause [RULE19]
    assign SO_O = so_reg;
    assign SO_OE_O = so_oe_reg & ~c_reg.hold_act;

    // Pins and frame toggle into the core clock
    fwph_sync #(.W(5)) u_pin_sync (
        .clk_i(CLOCK_I),
        .rst_n_i(ARST_N_I),
        .d_i({CS_N_I, HOLD_N_I, SCLK_I, WP_N_I, lr_reg.tog}),
        .q_o(core_s)
    );
    assign {cs_n_s, hold_n_s, sclk_s, wp_n_s, tog_s} = core_s;

    // Busy and latch are live, bit 15 reads zero [RULE14] [RULE15]
    assign status_word = {1'b0, c_reg.sr[14:2], c_reg.write_latch_flag, c_reg.busy};

    // Span of the requested operation, aligned to its size
    always_comb begin
        logic [4:0] lg;
        lg = LOG_PAGE; // Page span unless an erase says otherwise
        case (lr_reg.op)
            CMD_SECTOR: lg = LOG_SECTOR;
            CMD_BLK32: lg = LOG_BLK32;
            CMD_BLK64: lg = LOG_BLK64;
            default: lg = LOG_PAGE;
        endcase
        span_mask = (ADDR_W'(1) << lg) - ADDR_W'(1);
        start_a = lr_reg.addr[ADDR_W-1:0] & ~span_mask;
        end_a = start_a | span_mask;
    end

    // Guarded spans touch an array end, so two ends suffice [RULE9]
    fwph_region u_reg_start (
        .guard_i(c_reg.sr[SB_GUARD_HI:SB_GUARD_LO]),
        .invert_i(c_reg.sr[SB_INVERT]),
        .addr_i(start_a),
        .prot_o(prot_s)
    );
    fwph_region u_reg_end (
        .guard_i(c_reg.sr[SB_GUARD_HI:SB_GUARD_LO]),
        .invert_i(c_reg.sr[SB_INVERT]),
        .addr_i(end_a),
        .prot_o(prot_e)
    );

    // Busy time for an operation kind
    function automatic logic [CNT_W-1:0] cyc_of(input fwph_op_t k);
        case (k)
            OPK_SRW: cyc_of = CNT_W'(SRW_CYC - 1);
            OPK_PAGE: cyc_of = CNT_W'(PAGE_CYC - 1);
            OPK_SECTOR: cyc_of = CNT_W'(SECTOR_CYC - 1);
            OPK_BLOCK: cyc_of = CNT_W'(BLOCK_CYC - 1);
            default: cyc_of = CNT_W'(CHIP_CYC - 1);
        endcase
    endfunction

    // Frame ends when synchronised select rises on a new record
    assign exec = ~c_reg.cs_prev & cs_n_s & (tog_s != c_reg.seen_tog);
    // Lock by pin, or power-cycle and permanent lock codes [RULE17]
    assign sr_locked = (c_reg.sr[SB_LOCK_HI:SB_LOCK_LO] == LOCK_PIN &&
                        !wp_n_s) || c_reg.sr[SB_LOCK_HI];
    // Chip erase needs an empty guarded region [RULE18]
    assign chip_ok = c_reg.sr[SB_INVERT] ?
        (c_reg.sr[4:2] == 3'h7) : (c_reg.sr[4:2] == 3'h0);

    // New status contents after a write
    always_comb begin
        logic [15:0] raw;
        // One data byte updates the low half only
        raw = {c_reg.sr[15:8], lr_reg.addr[23:16]};
        // Second data byte carries the high half
        if (lr_reg.nbytes >= NB_SR_FULL) begin
            raw = {lr_reg.addr[15:8], lr_reg.addr[23:16]};
        end
        sr_new = (raw & SR_WMASK) | (c_reg.sr & ~SR_WMASK);
        sr_new = sr_new | (c_reg.sr & SR_OTP_MASK);
        // Guard pin low keeps guard and lock bits [RULE10]
        if (!wp_n_s) begin
            sr_new = (sr_new & ~SR_HW_MASK) | (c_reg.sr & SR_HW_MASK);
        end
    end

    // Core next state: pause, busy timer, command execution
    always_comb begin
        fwph_op_t k;
        logic ok;
        c_next = c_reg;
        c_next.op_start = 1'b0;
        c_next.cs_prev = cs_n_s;
        k = OPK_NONE;
        ok = 1'b0;
        // Pause level follows the pin only while clock is low
        if (cs_n_s) begin
            c_next.hold_act = 1'b0; // [RULE5]
        end else if (!sclk_s) begin
            c_next.hold_act = ~hold_n_s; // [RULE2] [RULE3]
        end
        // Timer ignores the pause entirely [RULE1]
        if (c_reg.busy) begin
            if (c_reg.cnt == '0) begin
                c_next.busy = 1'b0; // [RULE15]
                c_next.write_latch_flag = 1'b0; // [RULE8]
                if (c_reg.op == OPK_SRW) begin
                    c_next.sr = c_reg.sr_pend;
                end
            end else begin
                c_next.cnt = c_reg.cnt - CNT_W'(1);
            end
        end
        if (exec) begin
            c_next.seen_tog = tog_s;
            if (c_reg.dpd) begin
                // Only the wake command is heard [RULE11]
                if (lr_reg.op == CMD_WAKE && lr_reg.nbytes != 3'h0) begin
                    c_next.dpd = 1'b0;
                end
            end else if (!c_reg.busy && lr_reg.aligned) begin
                case (lr_reg.op)
                    CMD_ARM: c_next.write_latch_flag = 1'b1; // [RULE7]
                    CMD_DISARM: c_next.write_latch_flag = 1'b0; // [RULE8]
                    CMD_SLEEP: c_next.dpd = 1'b1;
                    CMD_SR_WRITE: begin
                        k = OPK_SRW;
                        ok = !sr_locked && lr_reg.nbytes >= NB_SR_LO;
                    end
                    CMD_PAGE: begin
                        k = OPK_PAGE;
                        ok = lr_reg.nbytes > NB_ADDR && !prot_s && !prot_e;
                    end
                    CMD_SECTOR: begin
                        k = OPK_SECTOR;
                        ok = lr_reg.nbytes == NB_ADDR && !prot_s && !prot_e;
                    end
                    CMD_BLK32, CMD_BLK64: begin
                        k = OPK_BLOCK;
                        ok = lr_reg.nbytes == NB_ADDR && !prot_s && !prot_e;
                    end
                    CMD_CHIP_A, CMD_CHIP_B: begin
                        k = OPK_CHIP;
                        ok = lr_reg.nbytes == 3'h1 && chip_ok; // [RULE18]
                    end
                    default: k = OPK_NONE;
                endcase
                // Clear latch refuses every write command [RULE16]
                if (ok && c_reg.write_latch_flag) begin
                    c_next.busy = 1'b1;
                    c_next.op = k;
                    c_next.cnt = cyc_of(k);
                    c_next.sr_pend = sr_new;
                    c_next.op_start = (k != OPK_SRW);
                    c_next.op_addr = start_a;
                end
            end
        end
    end

    // Core register
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            c_reg <= '{hold_act: 1'b0, cs_prev: 1'b1, seen_tog: 1'b0,
                       sr: SR_RESET, write_latch_flag: 1'b0, busy: 1'b0, cnt: '0,
                       op: OPK_NONE, dpd: 1'b0, sr_pend: SR_RESET,
                       op_start: 1'b0, op_addr: '0};
        end else begin
            c_reg <= c_next;
        end
    end

    assign STATUS_O = status_word;
    assign OP_START_O = c_reg.op_start;
    assign OP_KIND_O = c_reg.op;
    assign OP_ADDR_O = c_reg.op_addr;
    assign PAUSED_O = c_reg.hold_act;

    busy_keep_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE1]
        c_reg.busy && c_reg.hold_act && c_reg.cnt > 1 |=> c_reg.busy)
        else $error("busy dropped during pause");
    pause_start_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE2]
        !cs_n_s && !hold_n_s && !sclk_s |=> c_reg.hold_act)
        else $error("pause did not start");
    pause_end_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE3]
        c_reg.hold_act && sclk_s && !cs_n_s |=> c_reg.hold_act)
        else $error("pause ended with clock high");
    cs_clear_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE5]
        cs_n_s |=> !c_reg.hold_act)
        else $error("pause survived select high");
    so_float_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE19]
        c_reg.hold_act |-> !SO_OE_O)
        else $error("output driven during pause");
    latch_arm_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE7]
        exec && !c_reg.dpd && !c_reg.busy && lr_reg.aligned &&
        lr_reg.op == CMD_ARM |=> STATUS_O[SB_WEL])
        else $error("arm did not set latch");
    latch_clear_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE8]
        $fell(c_reg.busy) |-> !c_reg.write_latch_flag)
        else $error("latch kept after operation");
    sleep_filter_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE11]
        c_reg.dpd && exec && lr_reg.op != CMD_WAKE |=>
        c_reg.dpd && !c_reg.busy && $stable(c_reg.write_latch_flag))
        else $error("command heard in deep sleep");
    latch_gate_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE16]
        $rose(c_reg.busy) |-> $past(c_reg.write_latch_flag))
        else $error("write ran with latch clear");
    chip_gate_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE18]
        c_reg.op_start && c_reg.op == OPK_CHIP |-> chip_ok)
        else $error("chip erase with guarded region");
    region_gate_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE9]
        exec && !c_reg.busy && !c_reg.dpd && (prot_s || prot_e) &&
        (lr_reg.op == CMD_PAGE || lr_reg.op == CMD_SECTOR) |=> !c_reg.busy)
        else $error("guarded span was written");
endmodule

// ### tb/fwph_host.sv
/*
 * Host serial controller model: mode 0 frames with an optional pause.
 * Assumes frame() is called from one bench process at a time.
 */
`timescale 1ns/10ps
module fwph_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input logic so_i
);
    // Last sixteen bits sampled from the device output
    logic [15:0] rx;
    // Idle: clock still low, select and pause at pull-up level
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
        hold_n_o = 1'b1;
        rx = 16'h0;
    end
    // One serial clock pulse, 125 ns period
    task automatic pulse(input bit cap);
        #62.5 sclk_o = 1'b1;
        // Mode 0: host samples the device output on the rise
        if (cap) rx = {rx[14:0], so_i};
        #62.5 sclk_o = 1'b0;
    endtask
    // Frame of nb bytes from d, MSB first; pause before bit ps
    task automatic frame(input int nb, input logic [31:0] d, input int ps);
        cs_n_o = 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            if (i == ps) begin
                // Pause pin falls clear of the clock's falling edge
                #10 hold_n_o = 1'b0;
                #90;
                // Junk edges while paused; a real host may do this
                repeat (2) begin
                    si_o = ~si_o;
                    pulse(1'b0);
                end
                #100 hold_n_o = 1'b1;
            end
            si_o = d[31-i];
            pulse(1'b1);
        end
        // Released line shows the inverse, not a held value
        si_o = ~si_o;
        #30 cs_n_o = 1'b1;
        #50;
    endtask
endmodule

// ### tb/tb_top.sv
/*
 * Self-checking bench for the write-protect and pause block.
 * Assumes fwph_host drives the serial pins; results read at STATUS_O, the operation outputs, SO_OE_O and the host's rx.
 */
`timescale 1ns/10ps
module tb_top;
    import fwph_pkg::*;
    logic clk, arst_n, wp_n, sclk, cs_n, si, hold_n, so_oe, paused, so;
    logic op_start;
    logic [15:0] status, seen;
    logic [2:0] op_kind;
    logic [ADDR_W-1:0] op_addr;
    int mismatches, checked, starts;
    // Core clock, 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    fwph_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
        .hold_n_o(hold_n), .so_i(so));
    // Short busy counts; a long erase spans a whole paused read
    fwph_top #(.SRW_CYC(40), .PAGE_CYC(40), .SECTOR_CYC(600),
        .BLOCK_CYC(40), .CHIP_CYC(40)) u_dut (.CLOCK_I(clk),
        .ARST_N_I(arst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
        .HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so), .SO_OE_O(so_oe),
        .STATUS_O(status), .OP_START_O(op_start), .OP_KIND_O(op_kind),
        .OP_ADDR_O(op_addr), .PAUSED_O(paused));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait for busy to drop; a hang counts as a mismatch
    task automatic wait_idle();
        for (int n = 0; status[0] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
            if (n > 1000) begin
                mismatches++;
                test_done();
            end
        end
    endtask
    // Arm the latch, then send one frame
    task automatic send(input int nb, input logic [31:0] d);
        u_host.frame(1, {CMD_ARM, 24'h0}, 99);
        u_host.frame(nb, d, 99);
    endtask
    // Mid-cycle look: started operations, output floats when paused
    always @(negedge clk) begin
        if (op_start === 1'b1) begin
            starts++;
        end
        if (paused === 1'b1) begin
            seen <= 16'h1;
            check({15'h0, so_oe}, 16'h0);
        end
    end
    initial begin
        arst_n = 1'b0;
        wp_n = 1'b1;
        seen = 16'h0;
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check(status, 16'h0000);
        u_host.frame(4, {CMD_SECTOR, 24'h0}, 99);
        check(status, 16'h0000);
        // Arm with a pause and junk edges after bit three
        u_host.frame(1, {CMD_ARM, 24'h0}, 3);
        check(seen, 16'h1);
        check(status, 16'h0002);
        // Empty guarded region lets chip erase run
        u_host.frame(1, {CMD_CHIP_B, 24'h0}, 99);
        wait_idle();
        check({13'h0, op_kind}, {13'h0, OPK_CHIP});
        check(status, 16'h0000);
        $display("test latch and pause done");
        send(3, {CMD_SR_WRITE, 8'h04, 16'h0});
        check({14'h0, status[1:0]}, 16'h3);
        wait_idle();
        check(status, 16'h0004);
        send(4, {CMD_SECTOR, 24'h7ff000});
        check(status, 16'h0006);
        u_host.frame(1, {CMD_CHIP_A, 24'h0}, 99);
        check(status, 16'h0006);
        send(4, {CMD_SECTOR, 24'h0});
        check(status, 16'h0007);
        // Status read paused mid-byte while the erase keeps running
        u_host.frame(2, {CMD_RD_LO, 24'h0}, 12);
        check({8'h0, u_host.rx[7:0]}, 16'h0007);
        wait_idle();
        check({13'h0, op_kind}, {13'h0, OPK_SECTOR});
        check(status, 16'h0004);
        // Invert set: only the top 1/64 stays open
        send(3, {CMD_SR_WRITE, 8'h04, 8'h40, 8'h0});
        wait_idle();
        check(status, 16'h4004);
        u_host.frame(2, {CMD_RD_HI, 24'h0}, 99);
        check({8'h0, u_host.rx[7:0]}, 16'h0040);
        send(4, {CMD_SECTOR, 24'h0});
        check(status, 16'h4006);
        send(4, {CMD_SECTOR, 24'h7ff000});
        wait_idle();
        check(op_addr[22:7], 16'hffe0);
        $display("test guard region done");
        // Latch set first, so an obeyed disarm would show
        u_host.frame(1, {CMD_ARM, 24'h0}, 99);
        u_host.frame(1, {CMD_SLEEP, 24'h0}, 99);
        u_host.frame(1, {CMD_DISARM, 24'h0}, 99);
        check(status, 16'h4006);
        u_host.frame(1, {CMD_WAKE, 24'h0}, 99);
        u_host.frame(1, {CMD_DISARM, 24'h0}, 99);
        check(status, 16'h4004);
        // Lock code one, then guard pin low freezes the word
        // One data byte leaves the high half as it was
        send(2, {CMD_SR_WRITE, 8'h84, 16'h0});
        wait_idle();
        check(status, 16'h4084);
        @(posedge clk);
        #1 wp_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        send(3, {CMD_SR_WRITE, 8'h00, 8'h00, 8'h0});
        check(status, 16'h4086);
        // Chip erase and two open sectors, nothing guarded
        check(starts[15:0], 16'h0003);
        $display("test sleep and lock done");
        test_done();
    end
endmodule
